// *** rtl/core_exec_pkg.sv ***
/*
  Shared constants and types for the byte-operation and branch executor.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
package core_exec_pkg;
  localparam int DATA_W    = 8;
  localparam int PC_W      = 13;
  localparam int INSTR_W   = 14;
  localparam int FADDR_W   = 7;
  localparam int BUS_AW    = 8;
  localparam int BUS_DW    = 16;
  localparam int BR_LIT_W  = 11;

  // Opcode fields
  localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
  localparam logic [5:0] OPC_INC      = 6'h0A;
  localparam logic [5:0] OPC_OR_REG   = 6'h04;
  localparam logic [5:0] OPC_MOVE     = 6'h08;
  localparam logic [5:0] OPC_OR_LIT   = 6'h38;
  localparam logic [2:0] OPC_BRANCH   = 3'h5;

  // Instruction and latch field positions
  localparam int DEST_BIT     = 7;
  localparam int LATCH_HI_BIT = 4;
  localparam int LATCH_LO_BIT = 3;

  // Register map
  localparam logic [BUS_AW-1:0] ADR_ACCUM  = 8'h00;
  localparam logic [BUS_AW-1:0] ADR_STATUS = 8'h01;
  localparam logic [BUS_AW-1:0] ADR_PC     = 8'h02;
  localparam logic [BUS_AW-1:0] ADR_LATCH  = 8'h03;
  localparam int                FILE_SEL_BIT = 7;
  localparam int                STAT_ZERO_BIT  = 0;
  localparam int                STAT_FLUSH_BIT = 1;

  // Reset values and program counter step
  localparam logic [PC_W-1:0]   PC_RST    = 13'h0000;
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
  localparam logic              ZERO_RST  = 1'b0;
  localparam logic [PC_W-1:0]   PC_STEP   = 13'h0001;

  typedef enum logic [2:0] {
    OP_NOP       = 3'b000,
    OP_INC_SKIP  = 3'b001,
    OP_INC       = 3'b010,
    OP_OR_REG    = 3'b011,
    OP_MOVE      = 3'b100,
    OP_OR_LIT    = 3'b101,
    OP_BRANCH    = 3'b110
  } op_type;

  typedef enum logic {
    ST_EXEC  = 1'b0,
    ST_FLUSH = 1'b1
  } state_type;
endpackage

// *** rtl/exec_alu.sv ***
/*
  Combinational result path for the executor.
  Assumes operands are stable for the cycle; no state inside.
*/
`timescale 1ns/10ps
module exec_alu (
  input  wire core_exec_pkg::op_type                  op_i,
  input  wire logic [core_exec_pkg::DATA_W-1:0]       accum_i,
  input  wire logic [core_exec_pkg::DATA_W-1:0]       file_i,
  input  wire logic [core_exec_pkg::DATA_W-1:0]       lit_i,
  output logic      [core_exec_pkg::DATA_W-1:0]       result_o,
  output logic                                        zero_o
);
  always_comb begin
    case (op_i)
      core_exec_pkg::OP_INC_SKIP,
      core_exec_pkg::OP_INC:    result_o = file_i + 8'h01;
      core_exec_pkg::OP_OR_REG: result_o = accum_i | file_i;
      core_exec_pkg::OP_MOVE:   result_o = file_i;
      core_exec_pkg::OP_OR_LIT: result_o = accum_i | lit_i;
      default:                  result_o = accum_i;
    endcase
    zero_o = (result_o == 8'h00);
  end
endmodule

// *** rtl/byte_op_and_branch_exec.sv ***
/*
  Executor for increment, OR, move, branch and no-operation instructions,
  with its own 128-entry file register array and a plain register port.
  Assumes instructions arrive on the system clock, one per ready cycle.
*/
// Summary of operation
// - 7-bit address; dest bit picks accumulator or file
// - Increment-skip adds one, flags untouched
// - Zero result discards next instruction, two cycles
// - Branch loads literal, upper bits from latch
// - Branch takes two cycles, flags untouched
// - OR literal into accumulator, zero flag updated
// - Increment to chosen destination, zero flag updated
// - OR accumulator with file, zero flag updated
// - Move file to destination, zero flag updated
`timescale 1ns/10ps
module byte_op_and_branch_exec (
  input  wire logic                                    clk_sys_i,
  input  wire logic                                    rst_i,
  input  wire logic [core_exec_pkg::INSTR_W-1:0]       instr_i,
  input  wire logic                                    instr_valid_i,
  output logic                                         instr_ready_o,
  output logic      [core_exec_pkg::PC_W-1:0]          pc_o,
  output logic      [core_exec_pkg::DATA_W-1:0]        accum_o,
  output logic                                         zero_o,
  input  wire logic [core_exec_pkg::BUS_AW-1:0]        addr_i,
  input  wire logic [core_exec_pkg::BUS_DW-1:0]        wr_data_i,
  input  wire logic                                    wr_i,
  input  wire logic                                    rd_i,
  output logic      [core_exec_pkg::BUS_DW-1:0]        rd_data_o
);
  localparam int DW = core_exec_pkg::DATA_W;

  core_exec_pkg::state_type          state_reg;
  core_exec_pkg::op_type             op;
  logic                              ready_reg;
  logic [core_exec_pkg::PC_W-1:0]    pc_reg;
  logic [DW-1:0]                     accum_reg;
  logic                              zero_reg;
  logic [DW-1:0]                     latch_reg;
  logic [DW-1:0]                     file_mem [0:(1<<core_exec_pkg::FADDR_W)-1];
  logic [core_exec_pkg::BUS_DW-1:0]  rd_data_reg;
  logic                              skip_reg;
  logic [DW-1:0]                     alu_res;
  logic                              alu_zero;
  logic                              fire;
  logic                              dest_file;
  logic [core_exec_pkg::FADDR_W-1:0] faddr;
  logic                              byte_op;
  logic                              sets_zero;
  logic                              take_skip;
  logic                              bus_file;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  // Ready gates the take, so nothing slips in on the edge right after reset
  assign fire      = instr_valid_i && ready_reg && (state_reg == core_exec_pkg::ST_EXEC);
  assign faddr     = instr_i[core_exec_pkg::FADDR_W-1:0];
  assign dest_file = instr_i[core_exec_pkg::DEST_BIT];
  assign bus_file  = addr_i[core_exec_pkg::FILE_SEL_BIT];

  always_comb begin
    // Unlisted encodings fall back to no-operation
    if (instr_i[13:11] == core_exec_pkg::OPC_BRANCH) begin
      op = core_exec_pkg::OP_BRANCH;
    end else begin
      case (instr_i[13:8])
        core_exec_pkg::OPC_INC_SKIP: op = core_exec_pkg::OP_INC_SKIP;
        core_exec_pkg::OPC_INC:      op = core_exec_pkg::OP_INC;
        core_exec_pkg::OPC_OR_REG:   op = core_exec_pkg::OP_OR_REG;
        core_exec_pkg::OPC_MOVE:     op = core_exec_pkg::OP_MOVE;
        core_exec_pkg::OPC_OR_LIT:   op = core_exec_pkg::OP_OR_LIT;
        default:                     op = core_exec_pkg::OP_NOP;
      endcase
    end
  end

  assign byte_op   = (op == core_exec_pkg::OP_INC_SKIP) || (op == core_exec_pkg::OP_INC) ||
                     (op == core_exec_pkg::OP_OR_REG) || (op == core_exec_pkg::OP_MOVE);
  assign sets_zero = (op == core_exec_pkg::OP_INC) || (op == core_exec_pkg::OP_OR_REG) ||
                     (op == core_exec_pkg::OP_MOVE) || (op == core_exec_pkg::OP_OR_LIT);
  assign take_skip = (op == core_exec_pkg::OP_INC_SKIP) && alu_zero;

  exec_alu u_alu (
    .op_i     (op),
    .accum_i  (accum_reg),
    .file_i   (file_mem[faddr]),
    .lit_i    (instr_i[DW-1:0]),
    .result_o (alu_res),
    .zero_o   (alu_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: skip and branch spend a second, flushed cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= core_exec_pkg::ST_EXEC;
      ready_reg <= 1'b0;
      skip_reg  <= 1'b0;
    end else begin
      ready_reg <= 1'b1;
      if (fire && (take_skip || op == core_exec_pkg::OP_BRANCH)) begin
        state_reg <= core_exec_pkg::ST_FLUSH;
        ready_reg <= 1'b0;
        skip_reg  <= take_skip;
      end else begin
        state_reg <= core_exec_pkg::ST_EXEC;
        skip_reg  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter; execution wins over a software write
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pc_reg <= core_exec_pkg::PC_RST;
    end else if (fire && op == core_exec_pkg::OP_BRANCH) begin
      pc_reg <= {latch_reg[core_exec_pkg::LATCH_HI_BIT:core_exec_pkg::LATCH_LO_BIT],
                 instr_i[core_exec_pkg::BR_LIT_W-1:0]};
    end else if (fire || skip_reg) begin
      pc_reg <= pc_reg + core_exec_pkg::PC_STEP;
    end else if (wr_i && !bus_file && addr_i == core_exec_pkg::ADR_PC) begin
      pc_reg <= wr_data_i[core_exec_pkg::PC_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      accum_reg <= core_exec_pkg::ACCUM_RST;
    end else if (fire && ((byte_op && !dest_file) || op == core_exec_pkg::OP_OR_LIT)) begin
      accum_reg <= alu_res;
    end else if (wr_i && !bus_file && addr_i == core_exec_pkg::ADR_ACCUM) begin
      accum_reg <= wr_data_i[DW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero flag; increment-skip, branch and no-operation leave it alone
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      zero_reg <= core_exec_pkg::ZERO_RST;
    end else if (fire && sets_zero) begin
      zero_reg <= alu_zero;
    end else if (wr_i && !bus_file && addr_i == core_exec_pkg::ADR_STATUS) begin
      zero_reg <= wr_data_i[core_exec_pkg::STAT_ZERO_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Upper program counter latch, software only
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      latch_reg <= core_exec_pkg::LATCH_RST;
    end else if (wr_i && !bus_file && addr_i == core_exec_pkg::ADR_LATCH) begin
      latch_reg <= wr_data_i[DW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File registers; no reset, contents undefined until written
  always_ff @(posedge clk_sys_i) begin
    if (fire && byte_op && dest_file) begin
      file_mem[faddr] <= alu_res;
    end else if (wr_i && bus_file) begin
      file_mem[addr_i[core_exec_pkg::FADDR_W-1:0]] <= wr_data_i[DW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data valid one cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_reg <= 16'h0000;
    end else if (rd_i) begin
      if (bus_file) begin
        rd_data_reg <= {8'h00, file_mem[addr_i[core_exec_pkg::FADDR_W-1:0]]};
      end else begin
        case (addr_i)
          core_exec_pkg::ADR_ACCUM:  rd_data_reg <= {8'h00, accum_reg};
          core_exec_pkg::ADR_STATUS: rd_data_reg <= {14'h0000,
                                                     state_reg == core_exec_pkg::ST_FLUSH,
                                                     zero_reg};
          core_exec_pkg::ADR_PC:     rd_data_reg <= {3'h0, pc_reg};
          core_exec_pkg::ADR_LATCH:  rd_data_reg <= {8'h00, latch_reg};
          default:                   rd_data_reg <= 16'h0000;
        endcase
      end
    end else begin
      rd_data_reg <= 16'h0000;
    end
  end

  assign instr_ready_o = ready_reg;
  assign pc_o          = pc_reg;
  assign accum_o       = accum_reg;
  assign zero_o        = zero_reg;
  assign rd_data_o     = rd_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_dest_accum;
    @(posedge clk_sys_i) disable iff (rst_i)
    fire && byte_op && !dest_file |=> accum_reg == $past(alu_res);
  endproperty
  a_dest_accum: assert property (p_dest_accum) else $error("accumulator destination");

  property p_skip_flags;
    @(posedge clk_sys_i) disable iff (rst_i)
    fire && op == core_exec_pkg::OP_INC_SKIP && !wr_i |=> $stable(zero_reg);
  endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("skip changed zero flag");

  property p_skip_two;
    @(posedge clk_sys_i) disable iff (rst_i)
    fire && take_skip |=> !instr_ready_o ##1 instr_ready_o && pc_reg == $past(pc_reg, 2) + 13'h0002;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");

  property p_noskip;
    @(posedge clk_sys_i) disable iff (rst_i)
    fire && op == core_exec_pkg::OP_INC_SKIP && !alu_zero |=> instr_ready_o;
  endproperty
  a_noskip: assert property (p_noskip) else $error("skip taken on nonzero");

  property p_branch_pc;
    @(posedge clk_sys_i) disable iff (rst_i)
    fire && op == core_exec_pkg::OP_BRANCH |=>
      pc_reg == {$past(latch_reg[4:3]), $past(instr_i[10:0])};
  endproperty
  a_branch_pc: assert property (p_branch_pc) else $error("branch target wrong");

  property p_branch_two;
    @(posedge clk_sys_i) disable iff (rst_i)
    fire && op == core_exec_pkg::OP_BRANCH && !wr_i |=>
      $stable(zero_reg) && !instr_ready_o ##1 instr_ready_o;
  endproperty
  a_branch_two: assert property (p_branch_two) else $error("branch timing or flag");

  property p_or_lit;
    @(posedge clk_sys_i) disable iff (rst_i)
    fire && op == core_exec_pkg::OP_OR_LIT |=>
      accum_reg == ($past(accum_reg) | $past(instr_i[7:0]));
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("or literal result");

  property p_zero_flag;
    @(posedge clk_sys_i) disable iff (rst_i)
    fire && sets_zero |=> zero_reg == ($past(alu_res) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag mismatch");

  property p_nop;
    @(posedge clk_sys_i) disable iff (rst_i)
    fire && op == core_exec_pkg::OP_NOP && !wr_i |=>
      $stable(accum_reg) && $stable(zero_reg) && instr_ready_o &&
      pc_reg == $past(pc_reg) + 13'h0001;
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation side effect");
endmodule

// *** verif/byte_op_and_branch_exec_test.sv ***
/*
  Self-checking bench for the byte-operation and branch executor.
  Assumes the register map and opcodes of core_exec_pkg and one 100 MHz clock.
*/
`timescale 1ns/10ps
module byte_op_and_branch_exec_test;
  logic        clk_sys_i;
  logic        rst_i;
  logic [13:0] instr_i;
  logic        instr_valid_i;
  logic        instr_ready_o;
  logic [12:0] pc_o;
  logic [7:0]  accum_o;
  logic        zero_o;
  logic [7:0]  addr_i;
  logic [15:0] wr_data_i;
  logic        wr_i;
  logic        rd_i;
  logic [15:0] rd_data_o;
  int          failures;
  int          n_tests;
  logic [15:0] v;

  byte_op_and_branch_exec dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .pc_o(pc_o),
    .accum_o(accum_o), .zero_o(zero_o), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o));

  always #5 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [13:0] op(input logic [5:0] opc, input logic d, input logic [6:0] f);
    return {opc, d, f};
  endfunction

  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_sys_i);
    wr_i      <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    @(negedge clk_sys_i);
    d = rd_data_o;
  endtask

  // Waits for ready, then leaves nxt on the port for the cycle after the take
  task automatic issue(input logic [13:0] w, input logic [13:0] nxt = 14'h0000,
                       input logic nv = 1'b0);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    instr_i       <= w;
    instr_valid_i <= 1'b1;
    @(negedge clk_sys_i);
    while (instr_ready_o !== 1'b1 && n < 20) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 20) failures++;
    @(posedge clk_sys_i);
    instr_i       <= nxt;
    instr_valid_i <= nv;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_or_lit;
    bus_wr(core_exec_pkg::ADR_PC, 16'h0100);
    bus_wr(core_exec_pkg::ADR_ACCUM, 16'h0000);
    issue({core_exec_pkg::OPC_OR_LIT, 8'h00});
    @(negedge clk_sys_i);
    check(accum_o, 16'h0000);
    check(zero_o, 16'h0001);
    check(pc_o, 16'h0101);
    bus_rd(core_exec_pkg::ADR_PC, v);
    check(v, 16'h0101);
    bus_rd(core_exec_pkg::ADR_STATUS, v);
    check(v, 16'h0001);
    issue({core_exec_pkg::OPC_OR_LIT, 8'hA5});
    @(negedge clk_sys_i);
    check(accum_o, 16'h00A5);
    check(zero_o, 16'h0000);
    bus_rd(core_exec_pkg::ADR_ACCUM, v);
    check(v, 16'h00A5);
  endtask

  task automatic t_inc;
    bus_wr(8'hFF, 16'h00FF);
    bus_wr(8'h80, 16'h0041);
    bus_wr(core_exec_pkg::ADR_ACCUM, 16'h0033);
    issue(op(core_exec_pkg::OPC_INC, 1'b1, 7'h7F));
    @(negedge clk_sys_i);
    check(zero_o, 16'h0001);
    check(accum_o, 16'h0033);
    bus_rd(8'hFF, v);
    check(v, 16'h0000);
    issue(op(core_exec_pkg::OPC_INC, 1'b0, 7'h00));
    @(negedge clk_sys_i);
    check(accum_o, 16'h0042);
    check(zero_o, 16'h0000);
    bus_rd(8'h80, v);
    check(v, 16'h0041);
  endtask

  task automatic t_or_reg;
    bus_wr(8'h85, 16'h00F0);
    bus_wr(core_exec_pkg::ADR_ACCUM, 16'h000C);
    issue(op(core_exec_pkg::OPC_OR_REG, 1'b1, 7'h05));
    @(negedge clk_sys_i);
    check(accum_o, 16'h000C);
    check(zero_o, 16'h0000);
    bus_rd(8'h85, v);
    check(v, 16'h00FC);
    bus_wr(8'h86, 16'h0000);
    bus_wr(core_exec_pkg::ADR_ACCUM, 16'h0000);
    issue(op(core_exec_pkg::OPC_OR_REG, 1'b0, 7'h06));
    @(negedge clk_sys_i);
    check(accum_o, 16'h0000);
    check(zero_o, 16'h0001);
  endtask

  task automatic t_move;
    bus_wr(8'h87, 16'h0000);
    bus_wr(core_exec_pkg::ADR_ACCUM, 16'h00AA);
    issue(op(core_exec_pkg::OPC_MOVE, 1'b1, 7'h07));
    @(negedge clk_sys_i);
    check(zero_o, 16'h0001);
    check(accum_o, 16'h00AA);
    issue(op(core_exec_pkg::OPC_MOVE, 1'b0, 7'h05));
    @(negedge clk_sys_i);
    check(accum_o, 16'h00FC);
    check(zero_o, 16'h0000);
    bus_rd(8'h87, v);
    check(v, 16'h0000);
  endtask

  task automatic t_skip;
    bus_wr(core_exec_pkg::ADR_PC, 16'h0200);
    bus_wr(8'h90, 16'h00FE);
    bus_wr(core_exec_pkg::ADR_STATUS, 16'h0001);
    issue(op(core_exec_pkg::OPC_INC_SKIP, 1'b1, 7'h10));
    @(negedge clk_sys_i);
    check(instr_ready_o, 16'h0001);
    check(pc_o, 16'h0201);
    check(zero_o, 16'h0001);
    bus_rd(8'h90, v);
    check(v, 16'h00FF);
    bus_wr(core_exec_pkg::ADR_STATUS, 16'h0000);
    issue(op(core_exec_pkg::OPC_INC_SKIP, 1'b0, 7'h10), {core_exec_pkg::OPC_OR_LIT, 8'h55}, 1'b1);
    @(negedge clk_sys_i);
    check(instr_ready_o, 16'h0000);
    check(pc_o, 16'h0202);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    check(instr_ready_o, 16'h0001);
    check(pc_o, 16'h0203);
    check(accum_o, 16'h0000);
    check(zero_o, 16'h0000);
  endtask

  task automatic t_branch;
    logic [7:0]  lat [3] = '{8'h18, 8'h08, 8'hE7};
    logic [10:0] k   [3] = '{11'h7FF, 11'h123, 11'h000};
    logic [15:0] pcx [3] = '{16'h1FFF, 16'h0923, 16'h0000};
    for (int i = 0; i < 3; i++) begin
      bus_wr(core_exec_pkg::ADR_LATCH, {8'h00, lat[i]});
      bus_wr(core_exec_pkg::ADR_ACCUM, 16'h0000);
      bus_wr(core_exec_pkg::ADR_STATUS, {15'h0000, i[0]});
      issue({core_exec_pkg::OPC_BRANCH, k[i]}, {core_exec_pkg::OPC_OR_LIT, 8'hFF}, 1'b1);
      @(negedge clk_sys_i);
      check(instr_ready_o, 16'h0000);
      check(pc_o, pcx[i]);
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      @(negedge clk_sys_i);
      check(instr_ready_o, 16'h0001);
      check(zero_o, {15'h0000, i[0]});
      check(accum_o, 16'h0000);
      check(pc_o, pcx[i]);
      bus_rd(core_exec_pkg::ADR_LATCH, v);
      check(v, {8'h00, lat[i]});
    end
  endtask

  task automatic t_nop;
    bus_wr(core_exec_pkg::ADR_PC, 16'h0050);
    bus_wr(8'h88, 16'h005A);
    bus_wr(core_exec_pkg::ADR_ACCUM, 16'h003C);
    bus_wr(core_exec_pkg::ADR_STATUS, 16'h0001);
    issue(14'h0000);
    @(negedge clk_sys_i);
    check(pc_o, 16'h0051);
    check(accum_o, 16'h003C);
    check(zero_o, 16'h0001);
    check(instr_ready_o, 16'h0001);
    bus_rd(8'h88, v);
    check(v, 16'h005A);
    // Reads stand one cycle only, then fall back to zero
    @(negedge clk_sys_i);
    check(rd_data_o, 16'h0000);
    bus_wr(8'h10, 16'h00FF);
    bus_rd(8'h10, v);
    check(v, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i     = 1'b0;
    rst_i         = 1'b1;
    instr_i       = 14'h0000;
    instr_valid_i = 1'b0;
    addr_i        = 8'h00;
    wr_data_i     = 16'h0000;
    wr_i          = 1'b0;
    rd_i          = 1'b0;
    failures      = 0;
    n_tests       = 0;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_or_lit();
    t_inc();
    t_or_reg();
    t_move();
    t_skip();
    t_branch();
    t_nop();
    finish_test();
  end

  // Whole run is under two hundred cycles; this leaves ample margin
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule
